// ---- hdl/tmc_pkg.sv ----
// Package for the timer/counter: register map, field positions, resets, timing
package tmc_pkg;

  // Printed register indices; byte address is four times the index
  localparam logic [7:0] IDX_TIMER_COUNT      = 8'h01;
  localparam logic [7:0] IDX_COMPARATOR_ONE   = 8'h08;
  localparam logic [7:0] IDX_COMPARATOR_TWO   = 8'h0B;
  localparam logic [7:0] IDX_OPTION           = 8'h0C;
  localparam logic [7:0] IDX_PIN_DIRECTION    = 8'h0D;

  localparam int unsigned ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_TIMER_COUNT    = ADDR_W'(IDX_TIMER_COUNT * 4);
  localparam logic [ADDR_W-1:0] OFS_COMPARATOR_ONE = ADDR_W'(IDX_COMPARATOR_ONE * 4);
  localparam logic [ADDR_W-1:0] OFS_COMPARATOR_TWO = ADDR_W'(IDX_COMPARATOR_TWO * 4);
  localparam logic [ADDR_W-1:0] OFS_OPTION         = ADDR_W'(IDX_OPTION * 4);
  localparam logic [ADDR_W-1:0] OFS_PIN_DIRECTION  = ADDR_W'(IDX_PIN_DIRECTION * 4);

  // Option register fields
  localparam int unsigned OPT_COUNT_SOURCE_SELECT = 5;
  localparam int unsigned OPT_SOURCE_EDGE_SELECT  = 4;
  localparam int unsigned OPT_PRESCALER_ASSIGN    = 3;
  localparam int unsigned OPT_RATIO_SELECT_LSB    = 0;
  localparam int unsigned RATIO_SELECT_W          = 3;

  // Comparator one control fields
  localparam int unsigned CMP_OUTPUT              = 7;
  localparam int unsigned CMP_OUTPUT_ENABLE       = 6;
  localparam int unsigned CMP_COUNT_SELECT        = 4;

  // Reset values
  localparam logic [7:0] RST_TIMER_COUNT    = 8'h00;
  localparam logic [7:0] RST_COMPARATOR     = 8'hFF;
  localparam logic [7:0] RST_OPTION         = 8'hFF;
  localparam logic [5:0] RST_PIN_DIRECTION  = 6'h3F;
  localparam logic [7:0] RST_PRESCALER      = 8'h00;

  // Timing: one quarter phase per clock, four per instruction cycle
  localparam int unsigned TOSC_NS           = 4;
  localparam int unsigned CLK_MHZ           = 250;
  localparam int unsigned QUARTER_CYCLES    = (TOSC_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned PHASES_PER_CYCLE  = 4;
  localparam logic [1:0]  PHASE_SECOND      = 2'h1;
  localparam logic [1:0]  PHASE_FOURTH      = 2'h3;
  localparam logic [1:0]  WRITE_HOLD_CYCLES = 2'h2;

  typedef struct packed {
    logic [1:0]  phase;
    logic [7:0]  count;
    logic [1:0]  inhibit;
    logic [7:0]  presc;
    logic        src_prev;
    logic        sample;
    logic        pend;
    logic [7:0]  option;
    logic [7:0]  cmp1;
    logic [7:0]  cmp2;
    logic [5:0]  dir;
    logic [5:0]  pin_dir;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } tmc_state_type;

endpackage

// ---- hdl/tmc_sync2.sv ----
// Two-flop synchroniser for a level from outside the clock domain
`timescale 1ns/100ps
module tmc_sync2 (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_rstn,
  // Level in and out
  input  wire logic i_level,
  output logic      o_level
);
  logic meta;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      meta    <= 1'b0;
      o_level <= 1'b0;
    end else begin
      meta    <= i_level;
      o_level <= meta;
    end
  end
endmodule // tmc_sync2

// ---- hdl/tmc_timer.sv ----
// Eight-bit timer/counter with shared prescaler and APB register access
`timescale 1ns/100ps
// Notes on behaviour
// - Source select clear: count every instruction cycle while watchdog owns prescaler
// - Count write holds off increments two cycles
// - Pin counting needs source, comparator-select, output-enable set
// - Pin edge select: clear rising, set falling
// - Comparator select clear counts comparator; enable ignored
// - Prescaler belongs to timer or watchdog; clear gives timer
// - Prescaler count never visible to software
// - Prescaler ratios powers of two, 1:2 to 1:256
// - Sample source on second and fourth quarter phases
// - Prescaler divides external input, symmetric output
// - Increment three to seven periods after edge
// - Source select set forces count pin to input
// - Count register eight bits, read and write
// - Shared prescaler is an eight-bit counter
// - Count write clears prescaler when timer owns it
// - Reset clears prescaler to zero
module tmc_timer #(
  parameter int unsigned COUNT_PIN_BIT = 5
) (
  // Clock and reset
  input  wire logic                          i_clk,
  input  wire logic                          i_rstn,
  // APB slave
  input  wire logic                          i_psel,
  input  wire logic                          i_penable,
  input  wire logic                          i_pwrite,
  input  wire logic [tmc_pkg::ADDR_W-1:0]    i_paddr,
  input  wire logic [31:0]                   i_pwdata,
  output logic      [31:0]                   o_prdata,
  output logic                               o_pready,
  output logic                               o_pslverr,
  // Count sources
  input  wire logic                          i_external_count_pin,
  input  wire logic                          i_comparator_out,
  // Pin and status outputs
  output logic      [5:0]                    o_pin_direction,
  output logic      [7:0]                    o_timer_count,
  output logic                               o_prescaler_to_watchdog
);
  import tmc_pkg::*;

  // Only six direction bits exist, so a larger index cannot be served
  if (COUNT_PIN_BIT > 5) begin : g_bad_count_pin
    $error("COUNT_PIN_BIT must select one of six pins");
  end

  localparam tmc_state_type RESET_STATE = '{
    phase:    2'h0,
    count:    RST_TIMER_COUNT,
    inhibit:  2'h0,
    presc:    RST_PRESCALER,
    // Start as if already high, so a high level at reset is not an edge
    src_prev: 1'b1,
    sample:   1'b1,
    pend:     1'b0,
    option:   RST_OPTION,
    cmp1:     RST_COMPARATOR,
    cmp2:     RST_COMPARATOR,
    dir:      RST_PIN_DIRECTION,
    pin_dir:  RST_PIN_DIRECTION,
    prdata:   32'h0000_0000,
    pready:   1'b0,
    pslverr:  1'b0
  };

  tmc_state_type s;
  tmc_state_type next_s;

  logic pin_sync;
  logic cmp_sync;

  // Both sources arrive from outside the clock domain
  tmc_sync2 u_pin_sync (
    .i_clk   (i_clk),
    .i_rstn  (i_rstn),
    .i_level (i_external_count_pin),
    .o_level (pin_sync)
  );

  tmc_sync2 u_cmp_sync (
    .i_clk   (i_clk),
    .i_rstn  (i_rstn),
    .i_level (i_comparator_out),
    .o_level (cmp_sync)
  );

  logic                      count_src_sel;
  logic                      edge_sel;
  logic                      presc_to_wdt;
  logic [RATIO_SELECT_W-1:0] ratio;
  logic                      mode_pin;
  logic                      mode_cmp;
  logic                      ext_level;
  logic                      presc_tick;
  logic                      presc_out;
  logic                      sample_now;
  logic                      fresh_edge;
  logic                      cycle_end;
  logic                      want_inc;
  logic                      setup;
  logic                      complete;
  logic                      wr;
  logic                      mapped;
  logic [31:0]               rdata;

  always_comb begin
    next_s        = s;
    count_src_sel = s.option[OPT_COUNT_SOURCE_SELECT];
    edge_sel      = s.option[OPT_SOURCE_EDGE_SELECT];
    presc_to_wdt  = s.option[OPT_PRESCALER_ASSIGN];
    ratio         = s.option[OPT_RATIO_SELECT_LSB +: RATIO_SELECT_W];

    // Quarter phase sequencer; phase 3 closes the instruction cycle
    next_s.phase = s.phase + 2'h1;
    cycle_end    = (s.phase == PHASE_FOURTH);
    sample_now   = (s.phase == PHASE_SECOND) || (s.phase == PHASE_FOURTH);

    // Count source selection
    mode_pin = count_src_sel && s.cmp1[CMP_COUNT_SELECT]
               && s.cmp1[CMP_OUTPUT_ENABLE];
    mode_cmp = count_src_sel && !s.cmp1[CMP_COUNT_SELECT];
    // Inverting the pin turns falling edges into rising ones
    if (mode_pin) begin
      ext_level = pin_sync ^ edge_sel;
    end else if (mode_cmp) begin
      ext_level = cmp_sync;
    end else begin
      ext_level = 1'b0;
    end
    next_s.src_prev = ext_level;

    // Prescaler advances only while the timer owns it
    if (count_src_sel) begin
      presc_tick = ext_level && !s.src_prev;
    end else begin
      presc_tick = cycle_end;
    end
    if (!presc_to_wdt && presc_tick) begin
      next_s.presc = s.presc + 8'h01;
    end

    // Bit n of the counter has a period of 2^(n+1) ticks, half high, half low
    if (presc_to_wdt) begin
      presc_out = ext_level;
    end else begin
      presc_out = s.presc[ratio];
    end

    // Sample on two phases; a rising sample is held until the cycle ends
    fresh_edge = 1'b0;
    if (sample_now) begin
      next_s.sample = presc_out;
      fresh_edge    = presc_out && !s.sample;
      if (fresh_edge) begin
        next_s.pend = 1'b1;
      end
    end

    if (!count_src_sel && presc_to_wdt) begin
      want_inc = cycle_end;
    end else begin
      want_inc = cycle_end && (s.pend || fresh_edge);
    end
    if (cycle_end) begin
      next_s.pend = 1'b0;
    end

    // Increment, unless held off after a write
    if (cycle_end && (s.inhibit != 2'h0)) begin
      next_s.inhibit = s.inhibit - 2'h1;
    end else if (want_inc) begin
      next_s.count = s.count + 8'h01;
    end

    // APB: one wait state, data and response registered with pready
    setup    = i_psel && i_penable && !s.pready;
    complete = i_psel && i_penable && s.pready;
    wr       = complete && i_pwrite && !s.pslverr;
    mapped   = (i_paddr == OFS_TIMER_COUNT) || (i_paddr == OFS_COMPARATOR_ONE)
               || (i_paddr == OFS_COMPARATOR_TWO) || (i_paddr == OFS_OPTION)
               || (i_paddr == OFS_PIN_DIRECTION);

    // Option and direction are write-only; prescaler has no address at all
    rdata = 32'h0000_0000;
    if (i_paddr == OFS_TIMER_COUNT) begin
      rdata = {24'h00_0000, s.count};
    end else if (i_paddr == OFS_COMPARATOR_ONE) begin
      rdata = {24'h00_0000, cmp_sync, s.cmp1[6:0]};
    end else if (i_paddr == OFS_COMPARATOR_TWO) begin
      rdata = {24'h00_0000, s.cmp2};
    end

    next_s.pready = setup;
    if (setup) begin
      next_s.prdata  = i_pwrite ? 32'h0000_0000 : rdata;
      next_s.pslverr = !mapped;
    end else if (complete) begin
      next_s.prdata  = 32'h0000_0000;
      next_s.pslverr = 1'b0;
    end

    if (wr) begin
      if (i_paddr == OFS_TIMER_COUNT) begin
        // A write outranks an increment in the same cycle
        next_s.count   = i_pwdata[7:0];
        next_s.inhibit = WRITE_HOLD_CYCLES;
        next_s.pend    = 1'b0;
        next_s.sample  = 1'b0;
        if (!presc_to_wdt) begin
          next_s.presc = RST_PRESCALER;
        end
      end else if (i_paddr == OFS_COMPARATOR_ONE) begin
        next_s.cmp1[6:0] = i_pwdata[6:0];
      end else if (i_paddr == OFS_COMPARATOR_TWO) begin
        next_s.cmp2 = i_pwdata[7:0];
      end else if (i_paddr == OFS_OPTION) begin
        next_s.option = i_pwdata[7:0];
      end else if (i_paddr == OFS_PIN_DIRECTION) begin
        next_s.dir = i_pwdata[5:0];
      end
    end

    // Count pin becomes an input whenever the source select is set
    next_s.pin_dir = next_s.dir;
    if (next_s.option[OPT_COUNT_SOURCE_SELECT]) begin
      next_s.pin_dir[COUNT_PIN_BIT] = 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      s <= RESET_STATE;
    end else begin
      s <= next_s;
    end
  end

  assign o_prdata                = s.prdata;
  assign o_pready                = s.pready;
  assign o_pslverr               = s.pslverr;
  assign o_pin_direction         = s.pin_dir;
  assign o_timer_count           = s.count;
  assign o_prescaler_to_watchdog = s.option[OPT_PRESCALER_ASSIGN];

endmodule // tmc_timer

// ---- dv/tmc_timer_props.sv ----
// Port-level assertions for the timer/counter
`timescale 1ns/100ps
module tmc_timer_props #(
  parameter int unsigned COUNT_PIN_BIT = 5
) (
  // Clock and reset
  input wire logic                       i_clk,
  input wire logic                       i_rstn,
  // Bus
  input wire logic                       i_psel,
  input wire logic                       i_penable,
  input wire logic                       i_pwrite,
  input wire logic [tmc_pkg::ADDR_W-1:0] i_paddr,
  input wire logic [31:0]                i_pwdata,
  input wire logic [31:0]                o_prdata,
  input wire logic                       o_pready,
  input wire logic                       o_pslverr,
  // Status
  input wire logic [5:0]                 o_pin_direction,
  input wire logic [7:0]                 o_timer_count,
  input wire logic                       o_prescaler_to_watchdog
);
  import tmc_pkg::*;
  logic       wr;
  logic       wr_cnt;
  logic       mapped;
  logic       t_mode;
  logic [7:0] opt_q;
  logic [3:0] since_wr;
  assign wr     = i_psel && i_penable && i_pwrite && o_pready;
  assign wr_cnt = wr && (i_paddr == OFS_TIMER_COUNT);
  assign t_mode = !opt_q[5] && opt_q[3];
  assign mapped = i_paddr inside {OFS_TIMER_COUNT, OFS_COMPARATOR_ONE, OFS_COMPARATOR_TWO,
                                  OFS_OPTION, OFS_PIN_DIRECTION};
  // Option cannot be read back, so it is shadowed from bus writes
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      opt_q    <= RST_OPTION;
      since_wr <= 4'h0;
    end else begin
      if (wr && i_paddr == OFS_OPTION) opt_q <= i_pwdata[7:0];
      if (wr_cnt) since_wr <= 4'h0;
      else if (since_wr != 4'hF) since_wr <= since_wr + 4'h1;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  pready_pulse_a: assert property (o_pready |=> !o_pready)
    else $error("ready held longer than one cycle");
  one_wait_a: assert property (i_psel && i_penable && !o_pready |=> o_pready)
    else $error("ready not one cycle after access");
  slverr_map_a: assert property (o_pready |-> o_pslverr == !mapped)
    else $error("error response wrong for address");
  option_hidden_a: assert property (o_pready && !i_pwrite && i_paddr == OFS_OPTION
    |-> o_prdata == 32'h0) else $error("option read returned data");
  count_step_a: assert property ($changed(o_timer_count) && !$past(wr_cnt)
    && !$past(wr_cnt, 2) |-> o_timer_count == $past(o_timer_count) + 8'h01)
    else $error("count moved by other than one");
  write_hold_a: assert property (wr_cnt |=> ##2 $stable(o_timer_count)[*7])
    else $error("count advanced right after write");
  timer_rate_a: assert property (t_mode && $changed(o_timer_count) |->
    ##4 ($changed(o_timer_count) || !t_mode || since_wr < 4'hC))
    else $error("timer mode not one per instruction cycle");
  pin_input_a: assert property (opt_q[5] && $past(opt_q[5])
    |-> o_pin_direction[COUNT_PIN_BIT]) else $error("count pin not input");
  wdog_flag_a: assert property ($stable(opt_q)
    |-> o_prescaler_to_watchdog == opt_q[3]) else $error("prescaler owner flag wrong");
  cover property (wr_cnt);
  cover property (o_pready && o_pslverr);
  cover property (t_mode && $changed(o_timer_count));
endmodule // tmc_timer_props

// ---- dv/tmc_src_model.sv ----
// Far-side source model: external count pin and comparator output
`timescale 1ns/100ps
module tmc_src_model (
  // Clock
  input  wire logic i_clk,
  // Driven sources
  output logic      o_pin,
  output logic      o_cmp
);
  initial begin
    o_pin = 1'b0;
    o_cmp = 1'b1;
  end
  // Levels held 5..8 clocks: above the two-period minimum plus sync margin
  task automatic toggle(input bit use_cmp, input int n);
    int w;
    repeat (n) begin
      w = 4 + ($urandom % 4);
      @(posedge i_clk);
      if (use_cmp) o_cmp <= !o_cmp;
      else o_pin <= !o_pin;
      repeat (w) @(posedge i_clk);
    end
  endtask
endmodule // tmc_src_model

// ---- dv/tmc_timer_test.sv ----
// Self-checking bench for the timer/counter
`timescale 1ns/100ps
module tmc_timer_test;
  import tmc_pkg::*;
  logic              i_clk = 1'b0;
  logic              i_rstn = 1'b0;
  logic              i_psel = 1'b0;
  logic              i_penable = 1'b0;
  logic              i_pwrite = 1'b0;
  logic [ADDR_W-1:0] i_paddr = '0;
  logic [31:0]       i_pwdata = '0;
  logic [31:0]       o_prdata;
  logic              o_pready;
  logic              o_pslverr;
  logic              pin;
  logic              cmp;
  logic [5:0]        o_pin_direction;
  logic [7:0]        o_timer_count;
  logic              o_prescaler_to_watchdog;
  logic [31:0]       rd;
  logic              err;
  logic [7:0]        a;
  int                num_errors = 0;
  int                checked = 0;
  int                cycles = 0;
  int                ex;
  int                seed;
  always #2 i_clk = !i_clk;
  tmc_timer #(.COUNT_PIN_BIT(5)) i_dut (.i_clk, .i_rstn, .i_psel, .i_penable, .i_pwrite,
    .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_external_count_pin(pin),
    .i_comparator_out(cmp), .o_pin_direction, .o_timer_count, .o_prescaler_to_watchdog);
  tmc_src_model u_src (.i_clk, .o_pin(pin), .o_cmp(cmp));
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wait_clk(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  // Holds the request until ready is seen high at an edge
  task automatic apb(input logic w, input logic [ADDR_W-1:0] ad, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge i_clk);
    i_psel   <= 1'b1;
    i_pwrite <= w;
    i_paddr  <= ad;
    i_pwdata <= wd;
    @(posedge i_clk);
    i_penable <= 1'b1;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_pready !== 1'b1);
    rd = o_prdata;
    err = o_pslverr;
    i_psel    <= 1'b0;
    i_penable <= 1'b0;
    chk("bus wait", 32'd2, 32'(n));
    wait_clk(3);
  endtask
  task automatic edges(input bit c, input int n, input int inc);
    u_src.toggle(c, n);
    wait_clk(12);
    ex = (ex + inc) & 255;
    chk("edge count", ex, o_timer_count);
  endtask
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 30000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  initial begin
    seed = $urandom(32'hEA3387E1);
    wait_clk(5);
    i_rstn <= 1'b1;
    apb(1'b0, OFS_TIMER_COUNT, 32'h0);
    chk("count reset", 32'(RST_TIMER_COUNT), rd);
    apb(1'b0, OFS_COMPARATOR_ONE, 32'h0);
    chk("cmp1 reset", 32'hFF, rd);
    apb(1'b0, OFS_OPTION, 32'h0);
    chk("option read", 32'h0, rd);
    apb(1'b0, 8'hFC, 32'h0);
    chk("unmapped", 32'h1, 32'(err));
    chk("dir reset", 32'(RST_PIN_DIRECTION), 32'(o_pin_direction));
    ex = $urandom_range(255);
    apb(1'b1, OFS_COMPARATOR_TWO, 32'(ex));
    apb(1'b0, OFS_COMPARATOR_TWO, 32'h0);
    chk("cmp2 rw", 32'(ex), rd);
    apb(1'b1, OFS_PIN_DIRECTION, 32'h0);
    apb(1'b1, OFS_OPTION, 32'h08);
    chk("dir timer", 32'h0, 32'(o_pin_direction));
    chk("wdog owner", 32'h1, 32'(o_prescaler_to_watchdog));
    apb(1'b1, OFS_TIMER_COUNT, 32'hF8);
    chk("write hold", 32'hF8, 32'(o_timer_count));
    wait_clk(20);
    a = o_timer_count;
    wait_clk(40);
    chk("timer rate", 32'(8'(a + 8'h0A)), 32'(o_timer_count));
    for (int n = 0; n < 8; n++) begin
      apb(1'b1, OFS_OPTION, 32'(n));
      apb(1'b1, OFS_TIMER_COUNT, 32'h0);
      chk("timer owner", 32'h0, 32'(o_prescaler_to_watchdog));
      wait_clk((16 << n) + 12);
      a = o_timer_count;
      wait_clk(16 << n);
      chk("prescale ratio", 32'(8'(a + 8'h02)), 32'(o_timer_count));
    end
    apb(1'b1, OFS_COMPARATOR_ONE, 32'h50);
    apb(1'b1, OFS_OPTION, 32'h28);
    chk("dir forced", 32'h20, 32'(o_pin_direction));
    ex = $urandom_range(255);
    apb(1'b1, OFS_TIMER_COUNT, 32'(ex));
    apb(1'b0, OFS_TIMER_COUNT, 32'h0);
    chk("count rw", 32'(ex), rd);
    edges(1'b0, 10, 5);
    // Switch edge select with the pin high, so the switch itself is no edge
    edges(1'b0, 1, 1);
    apb(1'b1, OFS_OPTION, 32'h38);
    edges(1'b0, 1, 1);
    edges(1'b0, 1, 0);
    apb(1'b1, OFS_COMPARATOR_ONE, 32'h10);
    edges(1'b0, 4, 0);
    // Comparator low before it becomes the source, so entering is no edge
    u_src.toggle(1'b1, 1);
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, OFS_COMPARATOR_ONE, 32'(i * 64));
      edges(1'b1, 4, 2);
    end
    apb(1'b1, OFS_COMPARATOR_ONE, 32'h50);
    apb(1'b1, OFS_OPTION, 32'h20);
    // Leaves the prescaler odd, so a missing clear shows as a lost count
    u_src.toggle(1'b0, 4);
    apb(1'b1, OFS_TIMER_COUNT, 32'h0);
    ex = 0;
    edges(1'b0, 2, 1);
    edges(1'b0, 2, 0);
    tally_and_finish();
  end
endmodule // tmc_timer_test
bind tmc_timer tmc_timer_props #(.COUNT_PIN_BIT(COUNT_PIN_BIT)) u_props (.i_clk, .i_rstn,
  .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr,
  .o_pin_direction, .o_timer_count, .o_prescaler_to_watchdog);
